// file: aspc_core.sv
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module aspc_core import aspc_pkg::*; #(
	parameter int DIV_W = BAUD_W
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic rxd_i,
	input wire logic txd_i,
	output logic txd_o,
	output logic txd_oe_o,
	input wire logic wait_mode_i
);

	if (DIV_W < 1 || DIV_W > BAUD_W) begin : g_div_check
		$error("divisor width out of range");
	end

	typedef enum logic {T_IDLE, T_SHIFT} aspc_tx_state_t;

	aspc_ctrl1_t serial_control_one_reg;
	aspc_ctrl2_t serial_control_two_reg;
	aspc_stat1_t stat_reg;
	logic tx_ninth_reg;
	logic rx_ninth_reg;
	logic rx_edge_reg;
	logic [4:0] baud_hi_reg;
	logic [7:0] baud_lo_reg;
	logic [7:0] tx_buf_reg;
	logic [7:0] rx_buf_reg;
	logic arm_reg;
	logic idle_block_reg;
	logic rx_prev_reg;
	aspc_tx_state_t tx_state_reg;
	logic [10:0] tx_frame_reg;
	logic [3:0] tx_left_reg;
	logic [3:0] tx_phase_reg;

	logic run;
	logic tick;
	logic rx_src;
	logic rx_done;
	logic rx_idle;
	aspc_rx_frame_t rx_frame;
	logic wr_data;
	logic rd_data;
	logic rd_stat;
	logic clr_seq;
	logic xfer;
	logic tx_load;
	logic tx_finish;
	logic [8:0] tx_word;
	logic [12:0] divisor_full;

	// ==========================================================
	// decode and clocking
	assign wr_data = wr_i && addr_i == OFS_DATA;
	assign rd_data = rd_i && addr_i == OFS_DATA;
	assign rd_stat = rd_i && addr_i == OFS_STAT1;
	assign clr_seq = rd_data && arm_reg;
	assign xfer = rx_done && !stat_reg.rx_full_flag;
	assign run = !(serial_control_one_reg.stop_in_wait && wait_mode_i);
	assign divisor_full = {baud_hi_reg, baud_lo_reg};

	// receiver input: pin, own shifter, or the shared transmit wire
	always_comb begin
		if (!serial_control_one_reg.loop_select)
			rx_src = rxd_i;
		else if (serial_control_one_reg.receiver_source)
			rx_src = txd_i;
		else
			rx_src = txd_o;
	end

	aspc_baud #(
		.DIV_W(DIV_W)
	) u_baud (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.run_i(run),
		.divisor_i(divisor_full[DIV_W-1:0]),
		.tick_o(tick)
	);

	aspc_rx u_rx (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.tick_i(tick),
		.rxd_i(rx_src),
		.enable_i(serial_control_two_reg.rx_on),
		.nine_i(serial_control_one_reg.nine_bit),
		.par_on_i(serial_control_one_reg.parity_on),
		.par_odd_i(serial_control_one_reg.parity_odd),
		.done_o(rx_done),
		.frame_o(rx_frame),
		.idle_o(rx_idle)
	);

	// ==========================================================
	// control registers
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			serial_control_one_reg <= CTRL_RST;
			serial_control_two_reg <= CTRL_RST;
			tx_ninth_reg <= 1'b0;
			baud_hi_reg <= BAUDH_RST;
			baud_lo_reg <= BAUDL_RST;
			tx_buf_reg <= 8'h00;
		end else if (wr_i) begin
			case (addr_i)
				OFS_CTRL1: serial_control_one_reg <= wdata_i;
				OFS_CTRL2: serial_control_two_reg <= wdata_i;
				OFS_CTRL3: tx_ninth_reg <= wdata_i[C3_TX9_BIT];
				OFS_BAUDH: baud_hi_reg <= wdata_i[4:0];
				OFS_BAUDL: baud_lo_reg <= wdata_i;
				OFS_DATA: tx_buf_reg <= wdata_i;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// receive flags; a new character into an empty buffer wins over a clear in the same cycle
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			arm_reg <= 1'b0;
		end else if (rd_data) begin
			arm_reg <= 1'b0;
		end else if (rd_stat && (stat_reg.rx_full_flag || stat_reg.idle_flag ||
				stat_reg.overrun_flag)) begin
			arm_reg <= 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			stat_reg.rx_full_flag <= 1'b0;
			stat_reg.noise_flag <= 1'b0;
			stat_reg.framing_error_flag <= 1'b0;
			stat_reg.parity_error_flag <= 1'b0;
			rx_buf_reg <= 8'h00;
			rx_ninth_reg <= 1'b0;
		end else if (xfer) begin
			stat_reg.rx_full_flag <= 1'b1;
			stat_reg.noise_flag <= rx_frame.noise;
			stat_reg.framing_error_flag <= rx_frame.framing;
			stat_reg.parity_error_flag <= rx_frame.parity_err;
			rx_buf_reg <= rx_frame.data[7:0];
			rx_ninth_reg <= rx_frame.data[8];
		end else if (clr_seq) begin
			stat_reg.rx_full_flag <= 1'b0;
			stat_reg.noise_flag <= 1'b0;
			stat_reg.framing_error_flag <= 1'b0;
			stat_reg.parity_error_flag <= 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i)
			stat_reg.overrun_flag <= 1'b0;
		else if (rx_done && stat_reg.rx_full_flag)
			stat_reg.overrun_flag <= 1'b1;
		else if (clr_seq)
			stat_reg.overrun_flag <= 1'b0;
	end

	// idle stays down after its clear until a character lands
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			stat_reg.idle_flag <= 1'b0;
			idle_block_reg <= 1'b0;
		end else begin
			if (rx_idle && !idle_block_reg)
				stat_reg.idle_flag <= 1'b1;
			else if (clr_seq)
				stat_reg.idle_flag <= 1'b0;
			if (xfer)
				idle_block_reg <= 1'b0;
			else if (clr_seq && stat_reg.idle_flag)
				idle_block_reg <= 1'b1;
		end
	end

	// active edge is the falling one, seen in and out of frames
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			rx_prev_reg <= 1'b1;
			rx_edge_reg <= 1'b0;
		end else begin
			rx_prev_reg <= rx_src;
			if (serial_control_two_reg.rx_on && rx_prev_reg && !rx_src)
				rx_edge_reg <= 1'b1;
			else if (wr_i && addr_i == OFS_STAT2 && wdata_i[EDGE_BIT])
				rx_edge_reg <= 1'b0;
		end
	end

	// ==========================================================
	// transmitter
	always_comb begin
		tx_word = {tx_ninth_reg, tx_buf_reg};
		if (!serial_control_one_reg.nine_bit)
			tx_word[8] = 1'b1;
		if (serial_control_one_reg.parity_on) begin
			if (serial_control_one_reg.nine_bit)
				tx_word[8] = ^(tx_word & PAR_SPAN9) ^ serial_control_one_reg.parity_odd;
			else
				tx_word[7] = ^(tx_word & PAR_SPAN8) ^ serial_control_one_reg.parity_odd;
		end
	end

	// a frozen transmitter must not start a frame that it cannot clock out
	assign tx_load = serial_control_two_reg.tx_on && tx_state_reg == T_IDLE &&
		!stat_reg.tx_empty_flag && run;
	assign tx_finish = tx_state_reg == T_SHIFT && tick && tx_phase_reg == PH_LAST &&
		tx_left_reg == 4'h1;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			tx_state_reg <= T_IDLE;
			tx_frame_reg <= 11'h7FF;
			tx_left_reg <= 4'h0;
			tx_phase_reg <= PH_ZERO;
		end else begin
			case (tx_state_reg)
				T_IDLE: begin
					if (tx_load) begin
						tx_state_reg <= T_SHIFT;
						tx_frame_reg <= {1'b1, tx_word, 1'b0};
						tx_left_reg <= serial_control_one_reg.nine_bit ?
							FRAME_BITS9 : FRAME_BITS8;
						tx_phase_reg <= PH_ZERO;
					end
				end
				T_SHIFT: begin
					if (tick) begin
						tx_phase_reg <= tx_phase_reg + PH_FIRST;
						if (tx_phase_reg == PH_LAST) begin
							tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
							tx_left_reg <= tx_left_reg - 4'h1;
							if (tx_left_reg == 4'h1)
								tx_state_reg <= T_IDLE;
						end
					end
				end
				default: tx_state_reg <= T_IDLE;
			endcase
		end
	end

	// flags work whether or not their enables are set
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			stat_reg.tx_empty_flag <= 1'b1;
			stat_reg.tx_done_flag <= 1'b1;
		end else begin
			if (wr_data)
				stat_reg.tx_empty_flag <= 1'b0;
			else if (tx_load)
				stat_reg.tx_empty_flag <= 1'b1;
			if (wr_data)
				stat_reg.tx_done_flag <= 1'b0;
			else if (tx_finish && stat_reg.tx_empty_flag)
				stat_reg.tx_done_flag <= 1'b1;
		end
	end

	// break holds the line low only between frames
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			txd_o <= 1'b1;
			txd_oe_o <= 1'b0;
		end else begin
			txd_oe_o <= serial_control_two_reg.tx_on;
			if (tx_state_reg == T_SHIFT)
				txd_o <= tx_frame_reg[0];
			else
				txd_o <= !(serial_control_two_reg.tx_on && serial_control_two_reg.send_break);
		end
	end

	// ==========================================================
	// read port, data one cycle after the strobe
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				OFS_CTRL1: rdata_o <= serial_control_one_reg;
				OFS_CTRL2: rdata_o <= serial_control_two_reg;
				OFS_STAT1: rdata_o <= stat_reg;
				OFS_CTRL3: rdata_o <= {rx_ninth_reg, tx_ninth_reg, 6'h00};
				OFS_DATA: rdata_o <= rx_buf_reg;
				OFS_BAUDH: rdata_o <= {3'h0, baud_hi_reg};
				OFS_BAUDL: rdata_o <= baud_lo_reg;
				OFS_STAT2: rdata_o <= {rx_edge_reg, 7'h00};
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// ==========================================================
	// checks
	rx_clear_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		clr_seq && !rx_done |=> !stat_reg.rx_full_flag) else $error("rx full not cleared");

	err_with_full_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		$rose(stat_reg.noise_flag) || $rose(stat_reg.framing_error_flag) ||
		$rose(stat_reg.parity_error_flag) |->
		$rose(stat_reg.rx_full_flag)) else $error("error flag without rx full");

	overrun_drop_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		rx_done && stat_reg.rx_full_flag && !clr_seq |=>
		stat_reg.overrun_flag && $stable(rx_buf_reg)) else $error("overrun kept data");

	idle_hold_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		idle_block_reg && !stat_reg.idle_flag && !xfer |=> !stat_reg.idle_flag)
		else $error("idle set again before a character");

	edge_set_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		serial_control_two_reg.rx_on && rx_prev_reg && !rx_src |=> rx_edge_reg)
		else $error("edge flag missed");

	ctrl_reset_a: assert property (@(posedge clock_i)
		!resetn_i |=> serial_control_one_reg == CTRL_RST) else $error("control one reset");

endmodule : aspc_core
`default_nettype wire

// file: aspc_pkg.sv
package aspc_pkg;

	// ==========================================================
	// register map
	localparam int ADDR_W = 3;
	localparam int BAUD_W = 13;
	localparam logic [2:0] OFS_CTRL1 = 3'h0;
	localparam logic [2:0] OFS_CTRL2 = 3'h1;
	localparam logic [2:0] OFS_STAT1 = 3'h2;
	localparam logic [2:0] OFS_CTRL3 = 3'h3;
	localparam logic [2:0] OFS_DATA = 3'h4;
	localparam logic [2:0] OFS_BAUDH = 3'h5;
	localparam logic [2:0] OFS_BAUDL = 3'h6;
	localparam logic [2:0] OFS_STAT2 = 3'h7;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] BAUDL_RST = 8'h00;
	localparam logic [4:0] BAUDH_RST = 5'h00;
	localparam int C3_TX9_BIT = 6;
	localparam int EDGE_BIT = 7;

	// ==========================================================
	// field layouts, msb first
	typedef struct packed {
		logic loop_select;
		logic stop_in_wait;
		logic receiver_source;
		logic nine_bit;
		logic wake_sel;
		logic idle_type;
		logic parity_on;
		logic parity_odd;
	} aspc_ctrl1_t;

	typedef struct packed {
		logic tx_empty_irq_enable;
		logic tx_done_irq_enable;
		logic rx_full_irq_enable;
		logic idle_irq_enable;
		logic tx_on;
		logic rx_on;
		logic rx_wake;
		logic send_break;
	} aspc_ctrl2_t;

	typedef struct packed {
		logic tx_empty_flag;
		logic tx_done_flag;
		logic rx_full_flag;
		logic idle_flag;
		logic overrun_flag;
		logic noise_flag;
		logic framing_error_flag;
		logic parity_error_flag;
	} aspc_stat1_t;

	typedef struct packed {
		logic [8:0] data;
		logic noise;
		logic framing;
		logic parity_err;
	} aspc_rx_frame_t;

	// ==========================================================
	// framing: 16 sub-bit ticks per bit, majority of samples 7..9
	localparam logic [3:0] PH_ZERO = 4'h0;
	localparam logic [3:0] PH_FIRST = 4'h1;
	localparam logic [3:0] PH_LAST = 4'hF;
	localparam logic [3:0] SMP_A = 4'h7;
	localparam logic [3:0] SMP_B = 4'h8;
	localparam logic [3:0] SMP_C = 4'h9;
	localparam logic [3:0] LAST_BIT8 = 4'h7;
	localparam logic [3:0] LAST_BIT9 = 4'h8;
	localparam logic [3:0] FRAME_BITS8 = 4'hA;
	localparam logic [3:0] FRAME_BITS9 = 4'hB;
	localparam logic [7:0] IDLE_TICKS8 = 8'h9F;
	localparam logic [7:0] IDLE_TICKS9 = 8'hAF;
	localparam logic [8:0] PAR_SPAN8 = 9'h07F;
	localparam logic [8:0] PAR_SPAN9 = 9'h0FF;
	localparam logic [8:0] CHK_SPAN8 = 9'h0FF;
	localparam logic [8:0] CHK_SPAN9 = 9'h1FF;

endpackage : aspc_pkg

// file: aspc_baud.sv
`timescale 1ns/1ps
`default_nettype none
module aspc_baud #(
	parameter int DIV_W = 13
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic run_i,
	input wire logic [DIV_W-1:0] divisor_i,
	output logic tick_o
);

	// ==========================================================
	// one tick per divisor cycles, sixteen ticks per bit
	logic [DIV_W-1:0] count_reg;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			count_reg <= '0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (divisor_i == '0) begin
				count_reg <= '0;
			end else if (run_i) begin
				if (count_reg >= divisor_i - DIV_W'(1)) begin
					count_reg <= '0;
					tick_o <= 1'b1;
				end else begin
					count_reg <= count_reg + DIV_W'(1);
				end
			end
		end
	end

	baud_off_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		divisor_i == '0 |=> !tick_o) else $error("tick with zero divisor");

	baud_freeze_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		!run_i |=> !tick_o) else $error("tick while frozen");

endmodule : aspc_baud
`default_nettype wire

// file: aspc_rx.sv
`timescale 1ns/1ps
`default_nettype none
module aspc_rx import aspc_pkg::*; (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic tick_i,
	input wire logic rxd_i,
	input wire logic enable_i,
	input wire logic nine_i,
	input wire logic par_on_i,
	input wire logic par_odd_i,
	output logic done_o,
	output aspc_rx_frame_t frame_o,
	output logic idle_o
);

	typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} aspc_rx_state_t;

	aspc_rx_state_t state_reg;
	logic [3:0] phase_reg;
	logic [3:0] bit_reg;
	logic s7_reg;
	logic s8_reg;
	logic noise_reg;
	logic [8:0] data_reg;
	logic [7:0] idle_cnt_reg;
	logic idle_arm_reg;
	logic maj;
	logic disagree;
	logic [3:0] last_bit;
	logic [8:0] chk_span;

	assign maj = (s7_reg & s8_reg) | (s7_reg & rxd_i) | (s8_reg & rxd_i);
	assign disagree = !((s7_reg == s8_reg) && (s8_reg == rxd_i));
	assign last_bit = nine_i ? LAST_BIT9 : LAST_BIT8;
	assign chk_span = nine_i ? CHK_SPAN9 : CHK_SPAN8;

	// ==========================================================
	// frame receiver
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			state_reg <= R_IDLE;
			phase_reg <= PH_ZERO;
			bit_reg <= 4'h0;
			s7_reg <= 1'b1;
			s8_reg <= 1'b1;
			noise_reg <= 1'b0;
			data_reg <= 9'h000;
			done_o <= 1'b0;
			frame_o <= '0;
		end else begin
			done_o <= 1'b0;
			if (!enable_i) begin
				state_reg <= R_IDLE;
				phase_reg <= PH_ZERO;
			end else if (tick_i) begin
				phase_reg <= phase_reg + PH_FIRST;
				if (phase_reg == SMP_A)
					s7_reg <= rxd_i;
				if (phase_reg == SMP_B)
					s8_reg <= rxd_i;
				case (state_reg)
					R_IDLE: begin
						phase_reg <= PH_ZERO;
						if (!rxd_i) begin
							state_reg <= R_START;
							phase_reg <= PH_FIRST;
							noise_reg <= 1'b0;
							data_reg <= 9'h000;
						end
					end
					R_START: begin
						if (phase_reg == SMP_C) begin
							if (maj)
								state_reg <= R_IDLE;
							noise_reg <= disagree;
						end else if (phase_reg == PH_LAST) begin
							state_reg <= R_DATA;
							bit_reg <= 4'h0;
						end
					end
					R_DATA: begin
						if (phase_reg == SMP_C) begin
							data_reg[bit_reg] <= maj;
							noise_reg <= noise_reg | disagree;
						end else if (phase_reg == PH_LAST) begin
							if (bit_reg == last_bit)
								state_reg <= R_STOP;
							bit_reg <= bit_reg + 4'h1;
						end
					end
					R_STOP: begin
						if (phase_reg == SMP_C) begin
							// resync early so a back-to-back start is not missed
							state_reg <= R_IDLE;
							done_o <= 1'b1;
							frame_o.data <= data_reg;
							frame_o.noise <= noise_reg | disagree;
							frame_o.framing <= !maj;
							frame_o.parity_err <= par_on_i &&
								((^(data_reg & chk_span)) != par_odd_i);
						end
					end
					default: state_reg <= R_IDLE;
				endcase
			end
		end
	end

	// ==========================================================
	// idle line: one whole frame of high after some activity
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			idle_cnt_reg <= 8'h00;
			idle_arm_reg <= 1'b0;
			idle_o <= 1'b0;
		end else begin
			idle_o <= 1'b0;
			if (state_reg != R_IDLE || !rxd_i || !enable_i) begin
				idle_cnt_reg <= 8'h00;
				if (state_reg != R_IDLE)
					idle_arm_reg <= 1'b1;
			end else if (tick_i && idle_arm_reg) begin
				if (idle_cnt_reg == (nine_i ? IDLE_TICKS9 : IDLE_TICKS8)) begin
					idle_o <= 1'b1;
					idle_arm_reg <= 1'b0;
					idle_cnt_reg <= 8'h00;
				end else begin
					idle_cnt_reg <= idle_cnt_reg + 8'h01;
				end
			end
		end
	end

	done_pulse_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		done_o |=> !done_o) else $error("frame done longer than one cycle");

endmodule : aspc_rx
`default_nettype wire

// file: aspc_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// remote serial node: sends on the receive pin, decodes the transmit wire
module aspc_peer (
	input wire logic clock_i,
	input wire logic line_i,
	input wire logic nine_i,
	output logic line_o,
	output logic got_o,
	output logic [9:0] word_o
);
	int bit_div = 1;
	int nb;
	initial begin
		line_o = 1'b1;
		got_o = 1'b0;
		word_o = '0;
	end
	// ==========================================================
	// sender: one bit is 16 divided ticks, no gap after a high stop bit
	task automatic send(input logic [8:0] d, input logic stp);
		line_o <= 1'b0;
		repeat (16 * bit_div) @(posedge clock_i);
		for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
			line_o <= d[i];
			repeat (16 * bit_div) @(posedge clock_i);
		end
		line_o <= stp;
		repeat (16 * bit_div) @(posedge clock_i);
		// a low stop bit is released one edge before any next start
		if (!stp) begin
			line_o <= 1'b1;
			@(posedge clock_i);
		end
	endtask : send
	// ==========================================================
	// listener: samples mid bit, so a short edge skew is tolerated
	initial begin
		forever begin
			@(negedge line_i);
			repeat (8 * bit_div) @(posedge clock_i);
			nb = nine_i ? 9 : 8;
			word_o = '0;
			for (int i = 0; i < nb; i++) begin
				repeat (16 * bit_div) @(posedge clock_i);
				word_o[i] = line_i;
			end
			repeat (16 * bit_div) @(posedge clock_i);
			word_o[9] = line_i;
			got_o <= 1'b1;
			@(posedge clock_i);
			got_o <= 1'b0;
		end
	end
endmodule : aspc_peer
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module testbench import aspc_pkg::*;;
	localparam int LIMIT = 30000;
	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic wait_mode_i = 1'b0;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [7:0] wdata_i = 8'h00;
	logic nine_mode = 1'b0;
	logic rd_q = 1'b0;
	logic [15:0] mx;
	logic [7:0] b;
	logic [7:0] c;
	logic [9:0] tw;
	logic [31:0] seed = 32'h000017DF;
	logic [15:0] rq[$];
	logic [9:0] tq[$];
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	wire logic [7:0] rdata;
	wire logic txd;
	wire logic txd_oe;
	wire logic line_w;
	wire logic got;
	wire logic [9:0] word;
	// undriven transmit wire rests high through its pull-up
	wire logic txd_w = txd_oe ? txd : 1'b1;
	aspc_core #(.DIV_W(BAUD_W)) i_aspc_core (.clock_i(clock_i), .resetn_i(resetn_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
		.rxd_i(line_w), .txd_i(txd_w), .txd_o(txd), .txd_oe_o(txd_oe),
		.wait_mode_i(wait_mode_i));
	aspc_peer i_aspc_peer (.clock_i(clock_i), .line_i(txd_w), .nine_i(nine_mode),
		.line_o(line_w), .got_o(got), .word_o(word));
	initial begin
		forever #20 clock_i = ~clock_i;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	// ==========================================================
	// bus tasks: a gap cycle keeps each strobe assigned once per step
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
		@(posedge clock_i);
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		rq.push_back({m, e});
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(posedge clock_i);
	endtask : rd
	task automatic tx(input logic [7:0] d, input logic n9);
		wr(OFS_DATA, d);
		tq.push_back({1'b1, n9 & nine_mode, d});
	endtask : tx
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask : cyc
	task automatic wait_tx();
		while (tq.size() > 0) @(posedge clock_i);
		cyc(24);
	endtask : wait_tx
	task automatic wrap_up();
		// expectations never matched count against the run
		if (tq.size() != 0 || rq.size() != 0)
			n_errors++;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up
	// ==========================================================
	// watcher: read data stands only in the cycle after the strobe
	always @(posedge clock_i) begin
		cycles++;
		if (rd_q) begin
			mx = rq.pop_front();
			`CHK(rdata & mx[15:8], mx[7:0])
		end
		rd_q <= rd_i;
		if (got) begin
			tw = tq.pop_front();
			`CHK(word, tw)
		end
		if (cycles == LIMIT) begin
			n_errors++;
			wrap_up();
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		cyc(3);
		resetn_i <= 1'b1;
		rd(OFS_CTRL1, 8'hFF, CTRL_RST);
		rd(OFS_STAT1, 8'hFF, 8'hC0);
		b = rnd();
		wr(OFS_CTRL1, b);
		rd(OFS_CTRL1, 8'hFF, b);
		wr(OFS_CTRL2, 8'h0C);
		wr(OFS_CTRL1, 8'h20);
		for (int dv = 1; dv <= 3; dv++) begin
			wr(OFS_BAUDL, dv[7:0]);
			i_aspc_peer.bit_div = dv;
			tx(rnd(), 1'b0);
			wait_tx();
		end
		wr(OFS_BAUDL, 8'h01);
		i_aspc_peer.bit_div = 1;
		b = rnd();
		i_aspc_peer.send({1'b0, b}, 1'b1);
		cyc(250);
		rd(OFS_STAT2, 8'h80, 8'h80);
		wr(OFS_STAT2, 8'h80);
		rd(OFS_STAT2, 8'h80, 8'h00);
		rd(OFS_DATA, 8'hFF, b);
		rd(OFS_STAT1, 8'h30, 8'h30);
		rd(OFS_DATA, 8'hFF, b);
		rd(OFS_STAT1, 8'h30, 8'h00);
		cyc(400);
		rd(OFS_STAT1, 8'h10, 8'h00);
		b = rnd();
		c = rnd();
		i_aspc_peer.send({1'b0, b}, 1'b1);
		i_aspc_peer.send({1'b0, c}, 1'b0);
		cyc(40);
		rd(OFS_STAT1, 8'h2F, 8'h28);
		rd(OFS_DATA, 8'hFF, b);
		rd(OFS_STAT1, 8'h2F, 8'h00);
		c = rnd();
		i_aspc_peer.send({1'b0, c}, 1'b0);
		cyc(40);
		rd(OFS_STAT1, 8'h22, 8'h22);
		rd(OFS_DATA, 8'hFF, c);
		nine_mode = 1'b1;
		wr(OFS_CTRL1, 8'h10);
		wr(OFS_CTRL3, 8'h40);
		tx(rnd(), 1'b1);
		cyc(4);
		tx(rnd(), 1'b1);
		wait_tx();
		b = rnd();
		i_aspc_peer.send({1'b1, b}, 1'b1);
		cyc(40);
		rd(OFS_STAT1, 8'h20, 8'h20);
		rd(OFS_CTRL3, 8'h80, 8'h80);
		rd(OFS_DATA, 8'hFF, b);
		wr(OFS_CTRL3, 8'h00);
		tx(rnd(), 1'b0);
		wait_tx();
		nine_mode = 1'b0;
		wait_mode_i <= 1'b1;
		wr(OFS_CTRL1, 8'h00);
		tx(rnd(), 1'b0);
		wait_tx();
		wr(OFS_CTRL1, 8'h40);
		tx(rnd(), 1'b0);
		cyc(400);
		rd(OFS_STAT1, 8'hC0, 8'h00);
		wait_mode_i <= 1'b0;
		wait_tx();
		rd(OFS_STAT1, 8'h40, 8'h40);
		wr(OFS_CTRL1, 8'h80);
		b = rnd();
		c = rnd();
		fork
			i_aspc_peer.send({1'b0, c}, 1'b1);
			tx(b, 1'b0);
		join
		wait_tx();
		rd(OFS_STAT1, 8'h28, 8'h20);
		rd(OFS_DATA, 8'hFF, b);
		wr(OFS_CTRL1, 8'hA0);
		tx(c, 1'b0);
		wait_tx();
		rd(OFS_STAT1, 8'h28, 8'h20);
		rd(OFS_DATA, 8'hFF, c);
		// parity: even in loop puts the computed bit 7 on the wire
		wr(OFS_CTRL1, 8'h82);
		b = rnd();
		wr(OFS_DATA, b);
		tq.push_back({2'b10, ^b[6:0], b[6:0]});
		wait_tx();
		rd(OFS_STAT1, 8'h21, 8'h20);
		rd(OFS_DATA, 8'hFF, {^b[6:0], b[6:0]});
		// odd parity on the pin, peer sends the even bit: parity error
		wr(OFS_CTRL1, 8'h03);
		i_aspc_peer.send({1'b0, ^b[6:0], b[6:0]}, 1'b1);
		cyc(40);
		rd(OFS_STAT1, 8'h21, 8'h21);
		rd(OFS_DATA, 8'hFF, {^b[6:0], b[6:0]});
		// receiver off: edges on the pin must leave the flag clear
		wr(OFS_CTRL1, 8'h00);
		wr(OFS_CTRL2, 8'h08);
		wr(OFS_STAT2, 8'h80);
		i_aspc_peer.send({1'b0, rnd()}, 1'b1);
		cyc(20);
		rd(OFS_STAT2, 8'h80, 8'h00);
		cyc(4);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
